// *** status_reporting.sv ***
// How it works
// - cal condition high from configure to measured
// - condition reads leave contents unchanged
// - reset clears conditions; clear/preset don't
// - status bit 7 ORs enabled operation events
// - masks are full 16-bit read/write
// - operation event bit 0 latches calibration
// - operation event read returns and clears
// - clear empties events; reset keeps them
// - preset zeroes masks, nothing else
// - questionable condition always reads zero
// - status bit 3 ORs enabled bits 8,9
// - bit 8 on uncalibrated mode or check fail
// - bit 9 on ignored trigger
// - questionable event read returns and clears
// - service enable bits 3,7 raise service_request
// - error query pops oldest, else zero
`timescale 1ns/100ps
`default_nettype none
module status_reporting (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              reset_n,
	// command port
	input  wire status_pkg::cmd_t  cmd,
	output status_pkg::resp_t      resp,
	// calibration and trigger events
	input  wire logic              cal_config,
	input  wire logic              cal_done,
	input  wire logic              uncal_mode,
	input  wire logic              cal_test_fail,
	input  wire logic              trig_ignored,
	// error source
	input  wire logic              err_push,
	input  wire logic [15:0]       err_code,
	// status byte interface
	input  wire logic [7:0]        service_enable,
	output logic [7:0]             status_summary,
	output logic                   service_request
);
	logic        cal_busy;
	logic        next_cal_busy;
	logic [15:0] oper_evt;
	logic [15:0] next_oper_evt;
	logic [15:0] oper_mask;
	logic [15:0] next_oper_mask;
	logic [15:0] ques_evt;
	logic [15:0] next_ques_evt;
	logic [15:0] ques_mask;
	logic [15:0] next_ques_mask;
	status_pkg::resp_t next_resp;
	logic [7:0]  next_summary;
	logic        next_srq;
	logic        is_cmd_clear;
	logic        is_cmd_reset;
	logic        is_cmd_preset;
	logic        err_pop;
	logic [15:0] err_head;
	logic        err_empty;

	// sampling clock and reset for the checks below
	default clocking cb_main @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// command match helper
	function automatic logic is_cmd(input status_pkg::cmd_t c,
			input logic [3:0] code);
		is_cmd = c.valid && (c.code == code);
	endfunction : is_cmd

	// gated summary of one group
	function automatic logic summary(input logic [15:0] evt,
			input logic [15:0] mask, input logic [15:0] defined);
		summary = |(evt & mask & defined);
	endfunction : summary

	always_comb begin
		is_cmd_clear  = is_cmd(cmd, status_pkg::CMD_CLEAR);
		is_cmd_reset  = is_cmd(cmd, status_pkg::CMD_RESET);
		is_cmd_preset = is_cmd(cmd, status_pkg::CMD_PRESET);
		err_pop       = is_cmd(cmd, status_pkg::CMD_ERR_QUERY);
	end

	// error queue, flushed only by clear-status
	// pop and flush
	error_queue u_errq (
		.clk       (clk),
		.reset_n   (reset_n),
		.push      (err_push),
		.push_code (err_code),
		.pop       (err_pop),
		.flush     (is_cmd_clear),
		.head_code (err_head),
		.empty     (err_empty)
	);

	// calibration condition tracking
	always_comb begin
		next_cal_busy = cal_busy;
		if (cal_config)
			next_cal_busy = 1'b1;
		else if (cal_done)
			next_cal_busy = 1'b0;
		if (is_cmd_reset)
			next_cal_busy = 1'b0;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			cal_busy <= 1'b0;
		else
			cal_busy <= next_cal_busy;
	end

	// event latches; a new event wins over read-clear
	always_comb begin
		next_oper_evt = oper_evt;
		next_ques_evt = ques_evt;
		if (is_cmd(cmd, status_pkg::CMD_OPER_EVT))
			next_oper_evt = '0;
		if (is_cmd(cmd, status_pkg::CMD_QUES_EVT))
			next_ques_evt = '0;
		if (is_cmd_clear) begin
			next_oper_evt = '0;
			next_ques_evt = '0;
		end
		if (next_cal_busy && !cal_busy)
			next_oper_evt[status_pkg::OPER_CAL_BIT] = 1'b1;
		if (uncal_mode || cal_test_fail)
			next_ques_evt[status_pkg::QUES_CAL_BIT] = 1'b1;
		if (trig_ignored)
			next_ques_evt[status_pkg::QUES_TRIG_BIT] = 1'b1;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			oper_evt <= status_pkg::REG_RESET;
			ques_evt <= status_pkg::REG_RESET;
		end else begin
			oper_evt <= next_oper_evt;
			ques_evt <= next_ques_evt;
		end
	end

	// enable masks
	always_comb begin
		next_oper_mask = oper_mask;
		next_ques_mask = ques_mask;
		if (is_cmd(cmd, status_pkg::CMD_OPER_ENW))
			next_oper_mask = cmd.data;
		if (is_cmd(cmd, status_pkg::CMD_QUES_ENW))
			next_ques_mask = cmd.data;
		if (is_cmd_preset) begin
			next_oper_mask = '0;
			next_ques_mask = '0;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			oper_mask <= status_pkg::REG_RESET;
			ques_mask <= status_pkg::REG_RESET;
		end else begin
			oper_mask <= next_oper_mask;
			ques_mask <= next_ques_mask;
		end
	end

	// query answers and status byte
	always_comb begin
		next_resp.valid = cmd.valid;
		next_resp.data  = '0;
		if (cmd.valid) begin
			case (cmd.code)
				// condition read has no side effect
				status_pkg::CMD_OPER_COND:
					next_resp.data = {15'h0000, cal_busy};
				status_pkg::CMD_OPER_EVT:
					next_resp.data = oper_evt &
						status_pkg::OPER_DEFINED;
				status_pkg::CMD_OPER_ENA:
					next_resp.data = oper_mask;
				status_pkg::CMD_QUES_COND:
					next_resp.data = 16'h0000;
				status_pkg::CMD_QUES_EVT:
					next_resp.data = ques_evt &
						status_pkg::QUES_DEFINED;
				status_pkg::CMD_QUES_ENA:
					next_resp.data = ques_mask;
				status_pkg::CMD_ERR_QUERY:
					next_resp.data = err_empty ?
						status_pkg::ERR_NONE : err_head;
				default:
					next_resp.data = 16'h0000;
			endcase
		end
		next_summary = 8'h00;
		next_summary[status_pkg::STB_OPER_BIT] = summary(oper_evt,
			oper_mask, status_pkg::OPER_DEFINED);
		next_summary[status_pkg::STB_QUES_BIT] = summary(ques_evt,
			ques_mask, status_pkg::QUES_DEFINED);
		next_srq = |(next_summary & service_enable);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			resp            <= '0;
			status_summary  <= 8'h00;
			service_request <= 1'b0;
		end else begin
			resp            <= next_resp;
			status_summary  <= next_summary;
			service_request <= next_srq;
		end
	end

	// checks on conditions, events, masks, the status byte and the error query
	// condition follows configure
	a_cal_set: assert property (
		cal_config && !is_cmd_reset |=> cal_busy)
		else $error("cal condition not set");
	// condition read answers, no side effect
	a_oper_cond_read: assert property (
		is_cmd(cmd, status_pkg::CMD_OPER_COND) && !cal_config &&
		!cal_done |=> $stable(cal_busy) &&
		resp.data == {15'h0000, $past(cal_busy)})
		else $error("condition read wrong");
	a_reset_cond: assert property (
		is_cmd_reset |=> !cal_busy)
		else $error("reset left condition");
	a_mask_write: assert property (
		is_cmd(cmd, status_pkg::CMD_QUES_ENW) |=>
		ques_mask == $past(cmd.data))
		else $error("mask write lost");
	a_oper_latch: assert property (
		$rose(cal_busy) |-> oper_evt[status_pkg::OPER_CAL_BIT])
		else $error("oper event missed");
	a_oper_sum: assert property (
		status_summary[status_pkg::STB_OPER_BIT] ==
		$past(oper_evt[status_pkg::OPER_CAL_BIT] &&
		oper_mask[status_pkg::OPER_CAL_BIT]))
		else $error("oper summary wrong");
	a_oper_clr: assert property (
		is_cmd(cmd, status_pkg::CMD_OPER_EVT) && !cal_config |=>
		oper_evt == '0)
		else $error("oper event not cleared");
	a_oper_evt_read: assert property (
		is_cmd(cmd, status_pkg::CMD_OPER_EVT) |=>
		resp.data == $past(oper_evt & status_pkg::OPER_DEFINED))
		else $error("oper event read wrong");
	a_clear_events: assert property (
		is_cmd_clear && !cal_config && !uncal_mode &&
		!cal_test_fail && !trig_ignored |=>
		oper_evt == '0 && ques_evt == '0)
		else $error("clear left events");
	a_ques_cal_latch: assert property (
		uncal_mode || cal_test_fail |=>
		ques_evt[status_pkg::QUES_CAL_BIT])
		else $error("ques cal event missed");
	a_trig_latch: assert property (
		trig_ignored |=> ques_evt[status_pkg::QUES_TRIG_BIT])
		else $error("trigger event missed");
	a_ques_clr: assert property (
		is_cmd(cmd, status_pkg::CMD_QUES_EVT) && !uncal_mode &&
		!cal_test_fail && !trig_ignored |=> ques_evt == '0)
		else $error("ques event not cleared");
	a_preset_masks: assert property (
		is_cmd_preset |=> ##1 status_summary == 8'h00)
		else $error("preset left summary");
	a_ques_cond: assert property (
		is_cmd(cmd, status_pkg::CMD_QUES_COND) |=> resp.data == 16'h0)
		else $error("ques condition nonzero");
	a_ques_sum: assert property (
		status_summary[status_pkg::STB_QUES_BIT] ==
		$past(|(ques_evt & ques_mask & status_pkg::QUES_DEFINED)))
		else $error("ques summary wrong");
	// request follows summary and last enable
	a_service_request: assert property (
		service_request ==
		|(status_summary & $past(service_enable)))
		else $error("service request wrong");
	a_err_empty: assert property (
		err_pop && err_empty |=> resp.data == status_pkg::ERR_NONE)
		else $error("empty error query nonzero");

	// main scenarios worth seeing
	c_cal: cover property (@(posedge clk) $fell(cal_busy));
	c_srq: cover property (@(posedge clk) $rose(service_request));
	c_err: cover property (@(posedge clk) err_pop && !err_empty);
	c_preset: cover property (is_cmd_preset && status_summary != 8'h00);
	c_ques: cover property ($rose(status_summary[status_pkg::STB_QUES_BIT]));
endmodule : status_reporting
`default_nettype wire

// *** status_pkg.sv ***
`default_nettype none
package status_pkg;

	// query / command codes on the command port
	localparam logic [3:0] CMD_NONE      = 4'h0;
	localparam logic [3:0] CMD_OPER_COND = 4'h1;
	localparam logic [3:0] CMD_OPER_EVT  = 4'h2;
	localparam logic [3:0] CMD_OPER_ENA  = 4'h3;
	localparam logic [3:0] CMD_OPER_ENW  = 4'h4;
	localparam logic [3:0] CMD_QUES_COND = 4'h5;
	localparam logic [3:0] CMD_QUES_EVT  = 4'h6;
	localparam logic [3:0] CMD_QUES_ENA  = 4'h7;
	localparam logic [3:0] CMD_QUES_ENW  = 4'h8;
	localparam logic [3:0] CMD_PRESET    = 4'h9;
	localparam logic [3:0] CMD_CLEAR     = 4'ha;
	localparam logic [3:0] CMD_RESET     = 4'hb;
	localparam logic [3:0] CMD_ERR_QUERY = 4'hc;

	// field positions
	localparam int OPER_CAL_BIT  = 0;
	localparam int QUES_CAL_BIT  = 8;
	localparam int QUES_TRIG_BIT = 9;
	localparam int STB_QUES_BIT  = 3;
	localparam int STB_OPER_BIT  = 7;

	// defined bits per register
	localparam logic [15:0] OPER_DEFINED = 16'h0001;
	localparam logic [15:0] QUES_DEFINED = 16'h0300;
	localparam logic [15:0] REG_RESET    = 16'h0000;

	// error queue
	localparam int ERR_DEPTH = 8;
	localparam int ERR_PTR_W = 3;
	localparam logic [15:0] ERR_NONE = 16'h0000;

	typedef struct packed {
		logic        valid;
		logic [3:0]  code;
		logic [15:0] data;
	} cmd_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} resp_t;

endpackage : status_pkg
`default_nettype wire

// *** error_queue.sv ***
`timescale 1ns/100ps
`default_nettype none
module error_queue (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// push side
	input  wire logic        push,
	input  wire logic [15:0] push_code,
	// pop and flush
	input  wire logic        pop,
	input  wire logic        flush,
	// head of queue
	output logic [15:0]      head_code,
	output logic             empty
);
	logic [15:0]                        mem [status_pkg::ERR_DEPTH];
	logic [status_pkg::ERR_PTR_W-1:0]   rd_ptr;
	logic [status_pkg::ERR_PTR_W-1:0]   next_rd_ptr;
	logic [status_pkg::ERR_PTR_W-1:0]   wr_ptr;
	logic [status_pkg::ERR_PTR_W-1:0]   next_wr_ptr;
	logic [status_pkg::ERR_PTR_W:0]     count;
	logic [status_pkg::ERR_PTR_W:0]     next_count;
	logic                               do_push;
	logic                               do_pop;

	// pointer update; a full queue drops new errors
	always_comb begin
		do_push     = push && !flush &&
			(count != 4'(status_pkg::ERR_DEPTH));
		do_pop      = pop && !flush && (count != '0);
		next_rd_ptr = rd_ptr;
		next_wr_ptr = wr_ptr;
		next_count  = count;
		if (flush) begin
			next_rd_ptr = '0;
			next_wr_ptr = '0;
			next_count  = '0;
		end else begin
			if (do_push)
				next_wr_ptr = wr_ptr + 3'h1;
			if (do_pop)
				next_rd_ptr = rd_ptr + 3'h1;
			if (do_push && !do_pop)
				next_count = count + 4'h1;
			else if (do_pop && !do_push)
				next_count = count - 4'h1;
		end
	end

	// register pointers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_ptr <= '0;
			wr_ptr <= '0;
			count  <= '0;
		end else begin
			rd_ptr <= next_rd_ptr;
			wr_ptr <= next_wr_ptr;
			count  <= next_count;
		end
	end

	// storage
	always_ff @(posedge clk) begin
		if (do_push)
			mem[wr_ptr] <= push_code;
	end

	// head view
	always_comb begin
		empty     = (count == '0);
		head_code = empty ? status_pkg::ERR_NONE : mem[rd_ptr];
	end
endmodule : error_queue
`default_nettype wire

// *** status_reporting_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module status_reporting_tb;
	logic              clk;
	logic              reset_n;
	status_pkg::cmd_t  cmd;
	status_pkg::resp_t resp;
	logic              cal_config, cal_done, uncal_mode;
	logic              cal_test_fail, trig_ignored, err_push;
	logic [15:0]       err_code;
	logic [7:0]        service_enable, status_summary;
	logic              service_request;
	int                num_errors, checks;
	// behavioural model state
	int                cal_state, oper_evt, oper_ena, ques_evt, ques_ena;
	int                err_q[$];
	logic [15:0]       bound [4] = '{16'h8000, 16'h7fff, 16'hfffe, 16'hfcff};

	status_reporting dut (
		.clk            (clk),
		.reset_n        (reset_n),
		.cmd            (cmd),
		.resp           (resp),
		.cal_config     (cal_config),
		.cal_done       (cal_done),
		.uncal_mode     (uncal_mode),
		.cal_test_fail  (cal_test_fail),
		.trig_ignored   (trig_ignored),
		.err_push       (err_push),
		.err_code       (err_code),
		.service_enable (service_enable),
		.status_summary (status_summary),
		.service_request(service_request)
	);

	// clock
	always #10 clk = ~clk;

	task automatic check(input string name, input logic [15:0] seen,
			input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic finish_test();
		if (num_errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test

	// compare summary byte and service request against the model
	task automatic summary();
		logic [7:0] exp;
		repeat (3) @(negedge clk);
		exp = 8'h00;
		exp[7] = |(oper_evt & oper_ena & 16'h0001);
		exp[3] = |(ques_evt & ques_ena & 16'h0300);
		check("status_summary", {8'h00, status_summary}, {8'h00, exp});
		check("service_request", {15'h0, service_request},
			{15'h0, |(exp & service_enable)});
	endtask : summary

	// pulse one event input and update the model
	task automatic ev(input int which);
		@(posedge clk);
		case (which)
			0: cal_config <= 1'b1;
			1: cal_done <= 1'b1;
			2: uncal_mode <= 1'b1;
			3: cal_test_fail <= 1'b1;
			4: trig_ignored <= 1'b1;
			default: begin
				err_push <= 1'b1;
				err_code <= 16'($urandom);
			end
		endcase
		@(posedge clk);
		cal_config <= 1'b0;
		cal_done <= 1'b0;
		uncal_mode <= 1'b0;
		cal_test_fail <= 1'b0;
		trig_ignored <= 1'b0;
		err_push <= 1'b0;
		case (which)
			0: begin
				if (cal_state == 0) oper_evt = 1;
				cal_state = 1;
			end
			1: cal_state = 0;
			2, 3: ques_evt |= 16'h0100;
			4: ques_evt |= 16'h0200;
			default: if (err_q.size() < status_pkg::ERR_DEPTH)
				err_q.push_back(int'(err_code));
		endcase
		summary();
	endtask : ev

	// issue one command and compare the answer with the model
	task automatic run(input logic [3:0] code, input logic [15:0] data);
		logic [15:0] exp;
		exp = 16'h0000;
		case (code)
			status_pkg::CMD_OPER_COND: exp = 16'(cal_state);
			status_pkg::CMD_OPER_EVT: begin
				exp = 16'(oper_evt);
				oper_evt = 0;
			end
			status_pkg::CMD_OPER_ENA: exp = 16'(oper_ena);
			status_pkg::CMD_OPER_ENW: oper_ena = int'(data);
			status_pkg::CMD_QUES_EVT: begin
				exp = 16'(ques_evt);
				ques_evt = 0;
			end
			status_pkg::CMD_QUES_ENA: exp = 16'(ques_ena);
			status_pkg::CMD_QUES_ENW: ques_ena = int'(data);
			status_pkg::CMD_PRESET: begin
				oper_ena = 0;
				ques_ena = 0;
			end
			status_pkg::CMD_CLEAR: begin
				oper_evt = 0;
				ques_evt = 0;
				err_q.delete();
			end
			status_pkg::CMD_RESET: cal_state = 0;
			status_pkg::CMD_ERR_QUERY: if (err_q.size() > 0)
				exp = 16'(err_q.pop_front());
			default: ;
		endcase
		@(posedge clk);
		cmd <= '{1'b1, code, data};
		@(posedge clk);
		cmd <= '0;
		@(negedge clk);
		check("resp.valid", {15'h0, resp.valid}, 16'h0001);
		check("resp.data", resp.data, exp);
		summary();
	endtask : run

	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		finish_test();
	end

	initial begin
		{clk, reset_n, cal_config, cal_done, uncal_mode} = '0;
		{cal_test_fail, trig_ignored, err_push} = '0;
		cmd = '0;
		err_code = 16'h0000;
		service_enable = 8'h00;
		{num_errors, checks, cal_state, oper_evt, oper_ena} = '0;
		{ques_evt, ques_ena} = '0;
		void'($urandom(32'haaa8));
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		for (int c = 0; c <= 15; c++) run(4'(c), 16'h0000);
		for (int i = 0; i < 4; i++) begin
			run(status_pkg::CMD_OPER_ENW, bound[i]);
			run(status_pkg::CMD_OPER_ENA, 16'h0000);
			run(status_pkg::CMD_QUES_ENW, bound[i]);
			run(status_pkg::CMD_QUES_ENA, 16'h0000);
			ev(0);
			ev(2);
			ev(1);
		end
		@(posedge clk);
		service_enable <= 8'h88;
		run(status_pkg::CMD_OPER_ENW, 16'h0001);
		run(status_pkg::CMD_QUES_ENW, 16'h0200);
		ev(0);
		run(status_pkg::CMD_OPER_COND, 16'h0000);
		run(status_pkg::CMD_OPER_COND, 16'h0000);
		ev(4);
		ev(3);
		run(status_pkg::CMD_RESET, 16'h0000);
		run(status_pkg::CMD_OPER_COND, 16'h0000);
		run(status_pkg::CMD_PRESET, 16'h0000);
		run(status_pkg::CMD_OPER_EVT, 16'h0000);
		run(status_pkg::CMD_QUES_EVT, 16'h0000);
		for (int i = 0; i < 10; i++) ev(5);
		run(status_pkg::CMD_RESET, 16'h0000);
		for (int i = 0; i < 3; i++)
			run(status_pkg::CMD_ERR_QUERY, 16'h0000);
		ev(0);
		run(status_pkg::CMD_CLEAR, 16'h0000);
		run(status_pkg::CMD_ERR_QUERY, 16'h0000);
		run(status_pkg::CMD_OPER_COND, 16'h0000);
		// random mix of events and commands
		for (int i = 0; i < 300; i++) begin
			@(posedge clk);
			service_enable <= 8'($urandom);
			if ($urandom_range(1, 0) == 1)
				ev(int'($urandom_range(5, 0)));
			else
				run(4'($urandom_range(12, 1)), 16'($urandom));
		end
		finish_test();
	end
endmodule : status_reporting_tb
`default_nettype wire
